// >>> lxtc_pkg.sv
// constants, types and register map of the line exposure timing controller
//
// Behaviour
// - three capture modes: internal timed, sync width, sync edge with timed exposure
// - line frequency writes are refused while the external trigger is enabled
// - width-controlled exposure can be chosen only with the external trigger enabled
// - timed exposure takes the programmed length and starts at the line start
// - the programmed exposure length is used only in timed exposure
// - a new line frequency shortens the exposure when it no longer fits
// - in internal mode exposure writes are limited by the current line period
// - no generated line period is ever shorter than the sensor readout
// - sensor readout lasts 9.5 us and bounds the shortest line period
// - width mode: sync rise starts exposure, sync fall ends it and starts readout
// - exposure at least 7 us, sync low time above 1500 ns between exposures; width-mode exposures and sync low time are not checked
// - sync-edge timed mode starts the programmed exposure on a sync fall
// - one sync fall during an exposure is latched and served later, no more
// - a line frequency faster than 1/(7 us + 1500 ns) or than the readout allows is refused
// - sync falls faster than the line rate limit give lines at the limit only; in width mode early sync rises are dropped
// - internal line frequency accepted from 1 Hz up to the line rate limit of the link, 70 kHz at most
// - line rate limit: base 20k, base binned 41k, medium 41k, full 70k
// - after reset: internal line timer, timed exposure, free running
// - the sync pulse arrives on the first camera control line from the grabber
package lxtc_pkg;

  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned CLK_HZ       = CLK_MHZ * 1000000;

  // times in ns, cycle counts rounded up, the maximum exposure rounded down
  localparam int unsigned READOUT_NS   = 9500;
  localparam int unsigned LOW_NS       = 1500;
  localparam int unsigned MIN_EXP_NS   = 7000;
  localparam int unsigned MAX_EXP_NS   = 3000000;
  localparam int unsigned READOUT_CYC  = (READOUT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LOW_CYC      = (LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MIN_EXP_CYC  = (MIN_EXP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAX_EXP_CYC  = (MAX_EXP_NS / 1000) * CLK_MHZ;

  // line rate limits in Hz
  localparam int unsigned MIN_FREQ_HZ  = 1;
  localparam int unsigned RATE_BASE_HZ = 20000;
  localparam int unsigned RATE_BIN2_HZ = 41000;
  localparam int unsigned RATE_MED_HZ  = 41000;
  localparam int unsigned RATE_FULL_HZ = 70000;

  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_FREQ    = 8'h04;
  localparam logic [7:0]  ADDR_EXP     = 8'h08;
  localparam logic [7:0]  ADDR_STAT    = 8'h0c;
  localparam logic [7:0]  ADDR_PERIOD  = 8'h10;

  // field positions
  localparam int unsigned CTRL_TRIG_BIT  = 0;
  localparam int unsigned CTRL_WIDTH_BIT = 1;
  localparam int unsigned CTRL_LINK_LSB  = 2;
  localparam int unsigned STAT_ERR_BIT   = 0;
  localparam int unsigned STAT_EXP_BIT   = 1;
  localparam int unsigned STAT_PEND_BIT  = 2;
  localparam int unsigned STAT_BUSY_BIT  = 3;
  localparam int unsigned STAT_RO_BIT    = 4;

  // reset values
  localparam logic [31:0] FREQ_RST     = 32'h0000_1388;
  localparam logic [31:0] EXP_RST      = 32'h0000_03e8;

  typedef enum logic [1:0] {
    LINK_BASE      = 2'h0,
    LINK_BASE_BIN2 = 2'h1,
    LINK_MEDIUM    = 2'h2,
    LINK_FULL      = 2'h3
  } lxtc_link_e;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h1,
    ST_EXP_TIMED = 3'h2,
    ST_EXP_WIDTH = 3'h4
  } lxtc_state_e;

endpackage

// >>> lxtc_sync.sv
// two-stage synchroniser with edge pulses for the line sync input
`timescale 1ns/10ps
`default_nettype none
module lxtc_sync (
  // clock and control
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  // asynchronous level in
  input  wire logic din,
  // synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (ce) begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = ce & sync_r & ~prev_r;
  assign fall  = ce & ~sync_r & prev_r;

endmodule
`default_nettype wire

// >>> lxtc_top.sv
// line exposure timing controller: AHB-Lite registers, line timer, exposure sequencer
`timescale 1ns/10ps
`default_nettype none
module lxtc_top #(
  parameter int unsigned P_CLK_HZ      = lxtc_pkg::CLK_HZ,
  parameter int unsigned P_MAX_EXP_CYC = lxtc_pkg::MAX_EXP_CYC
) (
  // clock, reset, enable
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic        CE,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // line sync from the frame grabber
  input  wire logic        LINE_SYNC_PULSE,
  // sensor timing
  output logic             EXPOSE_ACTIVE,
  output logic             LINE_START,
  output logic             READOUT_START,
  output logic             READOUT_BUSY
);
  import lxtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // derived limits

  localparam logic [31:0] CLK_HZ_W   = 32'(P_CLK_HZ);
  localparam logic [31:0] RO_CYC     = 32'(READOUT_CYC);
  localparam logic [31:0] LOWC       = 32'(LOW_CYC);
  localparam logic [31:0] MINEXP     = 32'(MIN_EXP_CYC);
  localparam logic [31:0] MAXEXP     = 32'(P_MAX_EXP_CYC);
  localparam int unsigned MP_BASE    = (P_CLK_HZ + RATE_BASE_HZ - 1) / RATE_BASE_HZ;
  localparam int unsigned MP_BIN2    = (P_CLK_HZ + RATE_BIN2_HZ - 1) / RATE_BIN2_HZ;
  localparam int unsigned MP_MED     = (P_CLK_HZ + RATE_MED_HZ - 1) / RATE_MED_HZ;
  localparam int unsigned MP_FULL    = (P_CLK_HZ + RATE_FULL_HZ - 1) / RATE_FULL_HZ;
  localparam logic [31:0] PERIOD_RST = 32'(P_CLK_HZ / FREQ_RST);

  // highest line rate of a link configuration
  function automatic logic [31:0] max_rate(input lxtc_link_e l);
    case (l)
      LINK_BASE:      max_rate = 32'(RATE_BASE_HZ);
      LINK_BASE_BIN2: max_rate = 32'(RATE_BIN2_HZ);
      LINK_MEDIUM:    max_rate = 32'(RATE_MED_HZ);
      default:        max_rate = 32'(RATE_FULL_HZ);
    endcase
  endfunction

  // shortest line period in cycles, never below the readout
  function automatic logic [31:0] min_gap(input lxtc_link_e l);
    logic [31:0] p;
    case (l)
      LINK_BASE:      p = 32'(MP_BASE);
      LINK_BASE_BIN2: p = 32'(MP_BIN2);
      LINK_MEDIUM:    p = 32'(MP_MED);
      default:        p = 32'(MP_FULL);
    endcase
    min_gap = (p < RO_CYC) ? RO_CYC : p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic        trig_en_r;
  logic        width_sel_r;
  lxtc_link_e  link_r;
  logic [31:0] freq_r;
  logic [31:0] period_r;
  logic [31:0] exp_r;
  logic        err_r;
  logic        ap_wr_r;
  logic        ap_rd_r;
  logic [7:0]  ap_addr_r;
  logic        div_busy_r;
  logic [5:0]  div_cnt_r;
  logic [31:0] div_d_r;
  logic [31:0] div_q_r;
  logic [32:0] div_rem_r;
  logic        pend_r;
  lxtc_state_e st_r;
  logic [31:0] line_cnt_r;
  logic [31:0] exp_cnt_r;
  logic [31:0] exp_len_r;
  logic [31:0] ro_cnt_r;
  logic        ro_busy_r;
  logic        expose_r;
  logic        line_start_r;
  logic        ro_start_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;

  logic        sync_lvl;
  logic        sync_rise;
  logic        sync_fall;

  lxtc_sync u_sync (
    .clk   (CLK_SYS),
    .srst  (SRST),
    .ce    (CE),
    .din   (LINE_SYNC_PULSE),
    .level (sync_lvl),
    .rise  (sync_rise),
    .fall  (sync_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address phase, zero wait states

  logic take;
  logic wr_ctrl;
  logic wr_freq;
  logic wr_exp;
  logic wr_stat;

  assign take    = HSEL & HTRANS[1] & HREADY;
  assign wr_ctrl = ap_wr_r & (ap_addr_r == ADDR_CTRL);
  assign wr_freq = ap_wr_r & (ap_addr_r == ADDR_FREQ);
  assign wr_exp  = ap_wr_r & (ap_addr_r == ADDR_EXP);
  assign wr_stat = ap_wr_r & (ap_addr_r == ADDR_STAT);

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ap_wr_r     <= 1'b0;
      ap_rd_r     <= 1'b0;
      ap_addr_r   <= 8'h00;
      hreadyout_r <= 1'b0;
    end else if (CE) begin
      ap_wr_r     <= take & HWRITE;
      ap_rd_r     <= take & ~HWRITE;
      ap_addr_r   <= take ? {HADDR[7:2], 2'h0} : ap_addr_r;
      hreadyout_r <= 1'b1;
    end
  end

  // read data registered at the address phase edge
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      hrdata_r <= 32'h0000_0000;
    end else if (CE) begin
      if (take & ~HWRITE) begin
        case ({HADDR[7:2], 2'h0})
          ADDR_CTRL:   hrdata_r <= {28'h0000_000, link_r, width_sel_r, trig_en_r};
          ADDR_FREQ:   hrdata_r <= freq_r;
          ADDR_EXP:    hrdata_r <= exp_r;
          ADDR_STAT:   hrdata_r <= {27'h0000_000, (ro_cnt_r != 32'h0), div_busy_r,
                                    pend_r, expose_r, err_r};
          ADDR_PERIOD: hrdata_r <= period_r;
          default:     hrdata_r <= 32'h0000_0000;
        endcase
      end else begin
        hrdata_r <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  logic ctrl_bad;
  assign ctrl_bad = wr_ctrl & HWDATA[CTRL_WIDTH_BIT] & ~HWDATA[CTRL_TRIG_BIT];

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      trig_en_r   <= 1'b0;
      width_sel_r <= 1'b0;
      link_r      <= LINK_FULL;
    end else if (CE && wr_ctrl) begin
      trig_en_r   <= HWDATA[CTRL_TRIG_BIT];
      // width mode needs the trigger; dropping the trigger drops width mode
      width_sel_r <= HWDATA[CTRL_WIDTH_BIT] & HWDATA[CTRL_TRIG_BIT];
      link_r      <= lxtc_link_e'(HWDATA[CTRL_LINK_LSB +: 2]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line frequency: range check, then serial divide into a period

  logic        freq_bad;
  logic        div_done;
  logic        div_bad;
  logic [32:0] div_try;

  assign freq_bad = wr_freq & (trig_en_r | div_busy_r
                    | (HWDATA < 32'(MIN_FREQ_HZ)) | (HWDATA > max_rate(link_r)));
  assign div_try  = {div_rem_r[31:0], div_q_r[31]};
  assign div_done = div_busy_r & (div_cnt_r == 6'h00);
  // period must hold the readout and the shortest exposure plus low time
  assign div_bad  = div_done & ((div_q_r < RO_CYC) | (div_q_r < MINEXP + LOWC));

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      div_busy_r <= 1'b0;
      div_cnt_r  <= 6'h00;
      div_d_r    <= 32'h0000_0000;
      div_q_r    <= 32'h0000_0000;
      div_rem_r  <= 33'h0_0000_0000;
      freq_r     <= FREQ_RST;
      period_r   <= PERIOD_RST;
    end else if (CE) begin
      if (wr_freq && !freq_bad) begin
        div_busy_r <= 1'b1;
        div_cnt_r  <= 6'h20;
        div_d_r    <= HWDATA;
        div_q_r    <= CLK_HZ_W;
        div_rem_r  <= 33'h0_0000_0000;
      end else if (div_busy_r && div_cnt_r != 6'h00) begin
        div_cnt_r <= div_cnt_r - 6'h01;
        if (div_try >= {1'b0, div_d_r}) begin
          div_rem_r <= div_try - {1'b0, div_d_r};
          div_q_r   <= {div_q_r[30:0], 1'b1};
        end else begin
          div_rem_r <= div_try;
          div_q_r   <= {div_q_r[30:0], 1'b0};
        end
      end else if (div_done) begin
        div_busy_r <= 1'b0;
        if (!div_bad) begin
          freq_r   <= div_d_r;
          period_r <= div_q_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exposure time, in clock cycles

  logic exp_bad;
  assign exp_bad = wr_exp & (div_busy_r | (HWDATA < MINEXP) | (HWDATA > MAXEXP)
                   | (~trig_en_r & (HWDATA > period_r - LOWC)));

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      exp_r <= EXP_RST;
    end else if (CE) begin
      if (wr_exp && !exp_bad) begin
        exp_r <= HWDATA;
      end else if (div_done && !div_bad && (exp_r > div_q_r - LOWC)) begin
        exp_r <= div_q_r - LOWC;
      end
    end
  end

  // sticky parameter error, cleared by writing one; a new error wins
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      err_r <= 1'b0;
    end else if (CE) begin
      if (ctrl_bad | freq_bad | div_bad | exp_bad) begin
        err_r <= 1'b1;
      end else if (wr_stat && HWDATA[STAT_ERR_BIT]) begin
        err_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line start decision

  logic width_mode;
  logic edge_mode;
  logic gap_ok;
  logic start_timed;
  logic start_width;
  logic idle;

  assign width_mode  = trig_en_r & width_sel_r;
  assign edge_mode   = trig_en_r & ~width_sel_r;
  assign idle        = (st_r == ST_IDLE);
  assign gap_ok      = (line_cnt_r >= min_gap(link_r) - 32'h1);
  assign start_timed = idle & (trig_en_r ? (edge_mode & pend_r & gap_ok)
                                         : (line_cnt_r >= period_r - 32'h1));
  assign start_width = idle & width_mode & sync_rise & gap_ok;

  // one latched sync fall, extra falls are dropped
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      pend_r <= 1'b0;
    end else if (CE) begin
      if (!edge_mode) begin
        pend_r <= 1'b0;
      end else if (sync_fall) begin
        pend_r <= 1'b1;
      end else if (start_timed) begin
        pend_r <= 1'b0;
      end
    end
  end

  // cycles since the last line start, saturating
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      line_cnt_r <= 32'h0000_0000;
    end else if (CE) begin
      if (start_timed | start_width) begin
        line_cnt_r <= 32'h0000_0000;
      end else if (line_cnt_r != 32'hffff_ffff) begin
        line_cnt_r <= line_cnt_r + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exposure sequencer

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st_r         <= ST_IDLE;
      exp_cnt_r    <= 32'h0000_0000;
      exp_len_r    <= 32'h0000_0000;
      expose_r     <= 1'b0;
      line_start_r <= 1'b0;
      ro_start_r   <= 1'b0;
    end else if (CE) begin
      line_start_r <= 1'b0;
      ro_start_r   <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (start_timed) begin
            st_r         <= ST_EXP_TIMED;
            exp_len_r    <= exp_r;
            exp_cnt_r    <= 32'h0000_0001;
            expose_r     <= 1'b1;
            line_start_r <= 1'b1;
          end else if (start_width) begin
            st_r         <= ST_EXP_WIDTH;
            expose_r     <= 1'b1;
            line_start_r <= 1'b1;
          end
        end
        ST_EXP_TIMED: begin
          if (exp_cnt_r >= exp_len_r) begin
            st_r       <= ST_IDLE;
            expose_r   <= 1'b0;
            ro_start_r <= 1'b1;
          end else begin
            exp_cnt_r <= exp_cnt_r + 32'h1;
          end
        end
        ST_EXP_WIDTH: begin
          // sync fall ends the exposure; losing width mode ends it too
          if (sync_fall || !width_mode) begin
            st_r       <= ST_IDLE;
            expose_r   <= 1'b0;
            ro_start_r <= 1'b1;
          end
        end
        default: begin
          st_r     <= ST_IDLE;
          expose_r <= 1'b0;
        end
      endcase
    end
  end

  // readout window after each exposure
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ro_cnt_r  <= 32'h0000_0000;
      ro_busy_r <= 1'b0;
    end else if (CE) begin
      if (ro_start_r) begin
        ro_cnt_r  <= RO_CYC;
        ro_busy_r <= 1'b1;
      end else if (ro_cnt_r != 32'h0) begin
        ro_cnt_r  <= ro_cnt_r - 32'h1;
        ro_busy_r <= (ro_cnt_r != 32'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign HRDATA        = hrdata_r;
  assign HREADYOUT     = hreadyout_r;
  assign HRESP         = 1'b0 & hreadyout_r;
  assign EXPOSE_ACTIVE = expose_r;
  assign LINE_START    = line_start_r;
  assign READOUT_START = ro_start_r;
  assign READOUT_BUSY  = ro_busy_r;

  logic unused_ok;
  assign unused_ok = &{1'b0, HSIZE, HADDR[31:8], HADDR[1:0], sync_lvl, ap_rd_r};

endmodule
`default_nettype wire

// >>> lxtc_properties.sv
// assertions on the ports of the line exposure timing controller
`timescale 1ns/10ps
`default_nettype none
module lxtc_properties
  import lxtc_pkg::*;
#(
  parameter int unsigned P_CLK_HZ = CLK_HZ
) (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  // register bus
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  input  wire logic        HREADYOUT,
  input  wire logic        HRESP,
  // sync and sensor timing
  input  wire logic        LINE_SYNC_PULSE,
  input  wire logic        EXPOSE_ACTIVE,
  input  wire logic        LINE_START,
  input  wire logic        READOUT_START,
  input  wire logic        READOUT_BUSY
);
  localparam int unsigned RATE_GAP = (P_CLK_HZ + RATE_FULL_HZ - 1) / RATE_FULL_HZ;
  logic        ctrl_wr_r;
  logic        trig_r;
  logic        width_r;
  logic        width_seen_r;
  logic [19:0] gap_r;
  logic [19:0] exp_cnt_r;
  logic [19:0] busy_cnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // mirror of the mode bits taken from bus writes
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ctrl_wr_r <= 1'b0;
    end else begin
      ctrl_wr_r <= HSEL && HTRANS[1] && HREADY && HWRITE && (HADDR[7:2] == 6'h00);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      trig_r  <= 1'b0;
      width_r <= 1'b0;
    end else if (ctrl_wr_r) begin
      trig_r  <= HWDATA[CTRL_TRIG_BIT];
      width_r <= HWDATA[CTRL_TRIG_BIT] && HWDATA[CTRL_WIDTH_BIT];
    end
  end

  // cycles since the last line start, saturating
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      gap_r <= '1;
    end else if (LINE_START) begin
      gap_r <= 20'h1;
    end else if (gap_r != '1) begin
      gap_r <= gap_r + 20'h1;
    end
  end

  // lengths of exposure and readout
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      exp_cnt_r    <= 20'h0;
      busy_cnt_r   <= 20'h0;
      width_seen_r <= 1'b0;
    end else begin
      exp_cnt_r    <= EXPOSE_ACTIVE ? exp_cnt_r + 20'h1 : 20'h0;
      busy_cnt_r   <= (READOUT_BUSY && !READOUT_START) ? busy_cnt_r + 20'h1 : 20'h0;
      width_seen_r <= LINE_START ? width_r : (width_seen_r || width_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking dflt @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  sequence s_sync_rise;
    $rose(LINE_SYNC_PULSE);
  endsequence
  sequence s_sync_fall;
    $fell(LINE_SYNC_PULSE);
  endsequence
  sequence s_exp_end;
    $fell(EXPOSE_ACTIVE) ##0 READOUT_START;
  endsequence

  chk_start_opens_exp: assert property (LINE_START |-> $rose(EXPOSE_ACTIVE))
    else $error("line start without a new exposure");
  chk_exp_has_start: assert property ($rose(EXPOSE_ACTIVE) |-> LINE_START)
    else $error("exposure began without a line start");
  chk_end_readout: assert property ($fell(EXPOSE_ACTIVE) || READOUT_START
    |-> s_exp_end)
    else $error("readout start not tied to exposure end");
  chk_readout_len: assert property ($fell(READOUT_BUSY)
    |-> busy_cnt_r == READOUT_CYC)
    else $error("readout length wrong");
  chk_line_gap: assert property (LINE_START |-> gap_r >= READOUT_CYC
    && (!trig_r || gap_r >= RATE_GAP))
    else $error("line period too short");
  chk_min_exposure: assert property ($fell(EXPOSE_ACTIVE) && !width_seen_r
    |-> exp_cnt_r >= MIN_EXP_CYC)
    else $error("timed exposure too short");
  chk_edge_start: assert property (trig_r && !width_r && !EXPOSE_ACTIVE
    && gap_r > RATE_GAP + 10 ##0 s_sync_fall |-> ##[1:6] LINE_START)
    else $error("sync fall did not start exposure");
  chk_width_start: assert property (trig_r && width_r && !EXPOSE_ACTIVE
    && gap_r > RATE_GAP + 10 ##0 s_sync_rise |-> ##[1:6] LINE_START)
    else $error("sync rise did not start exposure");
  chk_width_end: assert property (trig_r && width_r && EXPOSE_ACTIVE
    ##0 s_sync_fall |-> ##[1:6] !EXPOSE_ACTIVE)
    else $error("sync fall did not end exposure");
  chk_bus_okay: assert property (!$past(SRST) |-> HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
endmodule

bind lxtc_top lxtc_properties #(.P_CLK_HZ(P_CLK_HZ)) i_props (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .LINE_SYNC_PULSE(LINE_SYNC_PULSE), .EXPOSE_ACTIVE(EXPOSE_ACTIVE), .LINE_START(LINE_START),
  .READOUT_START(READOUT_START), .READOUT_BUSY(READOUT_BUSY)
);
`default_nettype wire

// >>> lxtc_grabber.sv
// frame grabber model driving the line sync pulse
`timescale 1ns/10ps
`default_nettype none
module lxtc_grabber
  import lxtc_pkg::*;
(
  // clock
  input  wire logic clk,
  // sync on the first camera control line, idle low
  output var logic  sync
);
  initial sync = 1'b0;

  // low time always above 1500 ns between pulses
  task automatic pulses(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      sync <= 1'b1;
      repeat (hi) @(posedge clk);
      sync <= 1'b0;
      repeat ((lo > LOW_CYC) ? lo : LOW_CYC + 1) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// >>> line_exposure_timing_control_bench.sv
// self-checking bench for the line exposure timing controller
`timescale 1ns/10ps
`default_nettype none
module line_exposure_timing_control_bench;
  import lxtc_pkg::*;
  localparam int P_CLK    = 100000000;
  localparam int RATE_GAP = (P_CLK + RATE_FULL_HZ - 1) / RATE_FULL_HZ;
  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        sync;
  logic        line_start;
  logic        readout_start;
  int          errors  = 0;
  int          checks  = 0;
  int          w1, e1, w2, e2, n;

  always #5 clk_sys = ~clk_sys;

  lxtc_top #(.P_CLK_HZ(P_CLK)) i_dut (
    .CLK_SYS(clk_sys), .SRST(srst), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(), .LINE_SYNC_PULSE(sync), .EXPOSE_ACTIVE(),
    .LINE_START(line_start), .READOUT_START(readout_start), .READOUT_BUSY()
  );
  lxtc_grabber i_grab (.clk(clk_sys), .sync(sync));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic final_report;
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want,
                        input string what);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(what, v & m, want);
  endtask

  // frequency write, then poll until the divider is done
  task automatic wr_freq(input logic [31:0] f);
    logic [31:0] v;
    wr(ADDR_FREQ, f);
    do bus(1'b0, ADDR_STAT, 32'h0, v); while (v[STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic err_chk;
    rd_chk(ADDR_STAT, 32'h1, 32'h1, "error flag");
    wr(ADDR_STAT, 32'h1);
    rd_chk(ADDR_STAT, 32'h1, 32'h0, "error cleared");
  endtask

  // cycles to the next line start, then cycles to its readout start
  task automatic line(output int w, output int e);
    w = 0;
    e = 0;
    do begin
      @(posedge clk_sys);
      w++;
    end while (line_start !== 1'b1);
    do begin
      @(posedge clk_sys);
      e++;
    end while (readout_start !== 1'b1);
  endtask

  task automatic quiet(input int cycles, output int cnt);
    cnt = 0;
    repeat (cycles) begin
      @(posedge clk_sys);
      if (line_start === 1'b1) cnt++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(ADDR_CTRL, '1, 32'h0000_000c, "ctrl");
    rd_chk(ADDR_FREQ, '1, FREQ_RST, "freq");
    rd_chk(ADDR_EXP, '1, EXP_RST, "exposure");
    rd_chk(ADDR_PERIOD, '1, P_CLK / 5000, "period");
    wr(8'h14, 32'hffff_ffff);
    rd_chk(8'h14, '1, 32'h0, "unmapped");
  endtask

  task automatic t_freq;
    wr(ADDR_EXP, 32'd1800);
    wr_freq(32'd62500);
    rd_chk(ADDR_PERIOD, '1, 32'd1600, "period");
    rd_chk(ADDR_EXP, '1, 32'd1450, "clamped exposure");
    wr(ADDR_EXP, 32'd1451);
    err_chk();
    wr(ADDR_EXP, 32'd699);
    err_chk();
    rd_chk(ADDR_EXP, '1, 32'd1450, "exposure kept");
    wr_freq(32'd70001);
    err_chk();
    wr_freq(32'd0);
    err_chk();
    wr(ADDR_CTRL, 32'h0);
    wr_freq(32'd20001);
    err_chk();
    wr_freq(32'd20000);
    rd_chk(ADDR_PERIOD, '1, 32'd5000, "base period");
    wr(ADDR_CTRL, 32'h0000_000c);
    wr_freq(32'd62500);
    wr(ADDR_EXP, 32'd700);
    line(w1, e1);
    line(w2, e2);
    check("timed exposure", e1 inside {[700:702]}, 32'h1);
    check("line period", e1 + w2, 32'd1600);
  endtask

  task automatic t_edge;
    wr(ADDR_CTRL, 32'h0000_000e);
    err_chk();
    rd_chk(ADDR_CTRL, '1, 32'h0000_000c, "width refused");
    wr(ADDR_CTRL, 32'h0000_000d);
    wr_freq(32'd50000);
    err_chk();
    rd_chk(ADDR_PERIOD, '1, 32'd1600, "period kept");
    quiet(2000, n);
    check("free lines", n, 32'd0);
    fork
      i_grab.pulses(3, 20, 160);
      line(w1, e1);
    join
    line(w2, e2);
    check("start after fall", w1 inside {[20:28]}, 32'h1);
    check("edge exposure", e1 inside {[700:702]}, 32'h1);
    check("latched gap", (e1 + w2) inside {[RATE_GAP:RATE_GAP + 3]}, 32'h1);
    quiet(3000, n);
    check("extra lines", n, 32'd0);
  endtask

  task automatic t_width;
    wr(ADDR_CTRL, 32'h0000_000f);
    fork
      i_grab.pulses(1, 1000, 200);
      line(w1, e1);
    join
    check("start after rise", w1 inside {[1:8]}, 32'h1);
    check("width exposure", e1 inside {[998:1002]}, 32'h1);
  endtask

  task automatic t_fallback;
    wr(ADDR_CTRL, 32'h0000_000e);
    err_chk();
    rd_chk(ADDR_CTRL, '1, 32'h0000_000c, "fallback ctrl");
    line(w1, e1);
    line(w2, e2);
    check("fallback exposure", e1 inside {[700:702]}, 32'h1);
    check("fallback period", e1 + w2, 32'd1600);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_freq();
    t_edge();
    t_width();
    t_fallback();
    final_report();
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
